// ### shlf_top.sv
// Serial host-link framer: Wishbone registers, string framing, flow control, remote gating
`timescale 1ns/1ps
`default_nettype none
module shlf_top
    import shlf_pkg::*;
#(
    parameter int DEPTH = shlf_pkg::FIFO_DEPTH,
    parameter int CLK_FREQ = shlf_pkg::CLK_HZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rxd_i,
    output logic txd_o,
    input wire logic cts_n_i,
    output logic rts_n_o,
    input wire logic local_go_i,
    input wire logic local_stop_i,
    input wire logic motion_done_i,
    output logic go_o,
    output logic abort_o,
    output logic running_o,
    output logic remote_o
);
    localparam int LW = $clog2(DEPTH) + 1;

    // Pin synchronisers: rxd, cts_n, local go, local stop
    logic [3:0] sy1_q;
    logic [3:0] sy2_q;
    logic rxd_prev_q;
    logic go_prev_q;
    logic stop_prev_q;
    wire logic rxd_s = sy2_q[0];
    wire logic cts_n_s = sy2_q[1];
    wire logic lgo_s = sy2_q[2];
    wire logic lstop_s = sy2_q[3];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sy1_q <= 4'h1;
            sy2_q <= 4'h1;
            rxd_prev_q <= 1'b1;
            go_prev_q <= 1'b0;
            stop_prev_q <= 1'b0;
        end else if (ce_i) begin
            sy1_q <= {local_stop_i, local_go_i, cts_n_i, rxd_i};
            sy2_q <= sy1_q;
            rxd_prev_q <= rxd_s;
            go_prev_q <= lgo_s;
            stop_prev_q <= lstop_s;
        end
    end

    // Registers
    shlf_ctrl_t ctrl_q;
    shlf_ctrl_t ctrl_d;
    logic [15:0] csum_q;
    logic [31:0] csum_w;
    logic ack_q;
    logic [31:0] dat_q;

    // Wishbone decode
    wire logic req = wb_cyc_i && wb_stb_i && !ack_q;
    wire logic hit_ctrl = wb_adr_i == A_CTRL;
    wire logic hit_txd = wb_adr_i == A_TXDATA;
    wire logic hit_csum = wb_adr_i == A_CSUM;
    wire logic hit_stat = wb_adr_i == A_STAT;
    wire logic hit_rxd = wb_adr_i == A_RXDATA;
    wire logic hit_cmd = wb_adr_i == A_CMD;
    wire logic fifo_wr_ready;
    // A full FIFO stalls the bus cycle rather than dropping payload
    wire logic ack_d = req && (!(hit_txd && wb_we_i) || fifo_wr_ready);
    wire logic wr_acc = ack_d && wb_we_i;
    wire logic rd_acc = ack_d && !wb_we_i;
    wire logic [31:0] ctrl_nw = wb_merge(32'(ctrl_q), wb_dat_i, wb_sel_i);
    wire logic cmd_go = wr_acc && hit_cmd && wb_sel_i[0] && wb_dat_i[CMD_GO_BIT];
    wire logic cmd_stop = wr_acc && hit_cmd && wb_sel_i[0] && wb_dat_i[CMD_STOP_BIT];
    assign csum_w = wb_merge({16'h0000, csum_q}, wb_dat_i, wb_sel_i);

    always_comb begin
        ctrl_d = shlf_ctrl_t'(ctrl_nw[CTRL_W-1:0]);
        // Unsupported rate codes keep the current rate
        if (ctrl_d.baud > BR_19200) ctrl_d.baud = ctrl_q.baud;
    end

    // Framer state and FIFO
    shlf_state_t st_q;
    shlf_state_t st_d;
    shlf_entry_t fifo_in;
    shlf_entry_t fifo_out;
    wire logic fifo_rd_valid;
    wire logic [LW-1:0] fifo_level;
    wire logic tx_ready;
    wire logic tx_start;
    logic [7:0] tx_byte;

    assign fifo_in = '{last: wb_dat_i[TXD_LAST_BIT], data: wb_dat_i[7:0]};

    shlf_fifo #(
        .W($bits(shlf_entry_t)),
        .D(DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .wr_valid_i(req && wb_we_i && hit_txd),
        .wr_data_i(fifo_in),
        .wr_ready_o(fifo_wr_ready),
        .rd_valid_o(fifo_rd_valid),
        .rd_data_o(fifo_out),
        .rd_ready_i(tx_start && st_q == ST_PAY),
        .level_o(fifo_level)
    );

    // Receiver, used for flow-control characters and host bytes
    logic rx_busy_q;
    logic [3:0] rx_bit_q;
    logic [DIV_W-1:0] rx_cnt_q;
    logic [8:0] rx_sh_q;
    logic rx_valid_q;
    logic [7:0] rx_data_q;
    logic xoff_q;
    wire logic [DIV_W-1:0] div_w = baud_div(ctrl_q.baud, CLK_FREQ);
    wire logic rx_tick = rx_busy_q && rx_cnt_q == '0;
    wire logic rx_done = rx_tick && rx_bit_q == LAST_BIT_IDX && rxd_s;
    wire logic [7:0] rx_byte = rx_sh_q[8:1];
    wire logic sw_flow = ctrl_q.flow[0];
    wire logic hw_flow = ctrl_q.flow[1];
    wire logic rx_is_xon = sw_flow && rx_byte == B_XON;
    wire logic rx_is_xoff = sw_flow && rx_byte == B_XOFF;
    wire logic rx_store = rx_done && !rx_is_xon && !rx_is_xoff;
    wire logic rx_take = rd_acc && hit_rxd;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_busy_q <= 1'b0;
            rx_bit_q <= '0;
            rx_cnt_q <= '0;
            rx_sh_q <= '0;
        end else if (ce_i) begin
            if (!rx_busy_q) begin
                if (rxd_prev_q && !rxd_s) begin
                    rx_busy_q <= 1'b1;
                    rx_bit_q <= '0;
                    rx_cnt_q <= div_w >> 1; // Sample mid-bit
                end
            end else if (rx_tick) begin
                rx_cnt_q <= div_w - 1'b1;
                rx_sh_q <= {rxd_s, rx_sh_q[8:1]};
                rx_bit_q <= rx_bit_q + 1'b1;
                // Glitch that fails start check, or stop bit, ends the frame
                if ((rx_bit_q == '0 && rxd_s) || rx_bit_q == LAST_BIT_IDX) begin
                    rx_busy_q <= 1'b0;
                end
            end else begin
                rx_cnt_q <= rx_cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_valid_q <= 1'b0;
            rx_data_q <= '0;
            xoff_q <= 1'b0;
        end else if (ce_i) begin
            // New byte wins over a read in the same cycle
            if (rx_store) rx_valid_q <= 1'b1;
            else if (rx_take) rx_valid_q <= 1'b0;
            if (rx_store) rx_data_q <= rx_byte;
            if (!sw_flow) xoff_q <= 1'b0;
            else if (rx_done && rx_is_xoff) xoff_q <= 1'b1;
            else if (rx_done && rx_is_xon) xoff_q <= 1'b0;
        end
    end

    // Transmit gating by flow control
    wire logic flow_ok = !(sw_flow && xoff_q) && !(hw_flow && cts_n_s);
    wire logic st_sending = st_q != ST_IDLE && !(st_q == ST_PAY && !fifo_rd_valid);
    assign tx_start = st_sending && tx_ready && flow_ok;

    // Byte selection per state
    always_comb begin
        case (st_q)
            ST_STX: tx_byte = B_STX;
            ST_PAY: tx_byte = fifo_out.data;
            ST_ETX: tx_byte = B_ETX;
            ST_CSH: tx_byte = csum_q[15:8];
            ST_CSL: tx_byte = csum_q[7:0];
            ST_TRM1: tx_byte = (ctrl_q.term == TM_LF) ? B_LF : B_CR;
            ST_TRM2: tx_byte = B_LF;
            default: tx_byte = 8'h00;
        endcase
    end

    wire shlf_state_t after_etx = ctrl_q.csum_en ? ST_CSH : ST_TRM1;
    wire shlf_state_t after_pay = ctrl_q.frame_en ? ST_ETX : after_etx;

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: if (fifo_rd_valid) st_d = ctrl_q.frame_en ? ST_STX : ST_PAY;
            ST_STX: if (tx_start) st_d = ST_PAY;
            ST_PAY: if (tx_start && fifo_out.last) st_d = after_pay;
            ST_ETX: if (tx_start) st_d = after_etx;
            ST_CSH: if (tx_start) st_d = ST_CSL;
            ST_CSL: if (tx_start) st_d = ST_TRM1;
            ST_TRM1: if (tx_start) st_d = (ctrl_q.term == TM_CRLF) ? ST_TRM2 : ST_IDLE;
            ST_TRM2: if (tx_start) st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end

    shlf_uart_tx u_tx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .div_i(div_w),
        .start_i(tx_start),
        .data_i(tx_byte),
        .ready_o(tx_ready),
        .txd_o(txd_o)
    );

    // Motion control gating
    logic run_q;
    logic go_q;
    logic abort_q;
    logic rts_n_q;
    wire logic go_evt = cmd_go || (lgo_s && !go_prev_q && !ctrl_q.remote);
    // Local stop stays live even in remote mode
    wire logic stop_evt = cmd_stop || (lstop_s && !stop_prev_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q <= 1'b0;
            go_q <= 1'b0;
            abort_q <= 1'b0;
            rts_n_q <= 1'b0;
        end else if (ce_i) begin
            abort_q <= stop_evt;
            go_q <= go_evt && !stop_evt;
            // Stop clears the run state; a later go starts afresh, never resumes
            if (stop_evt) run_q <= 1'b0;
            else if (go_evt) run_q <= 1'b1;
            else if (motion_done_i) run_q <= 1'b0;
            rts_n_q <= hw_flow && rx_valid_q;
        end
    end

    // Register writes and read data
    logic [31:0] stat_w;
    logic [31:0] rdata_w;

    always_comb begin
        stat_w = '0;
        stat_w[ST_BUSY_BIT] = st_q != ST_IDLE;
        stat_w[ST_FULL_BIT] = !fifo_wr_ready;
        stat_w[ST_XOFF_BIT] = xoff_q;
        stat_w[ST_CTS_BIT] = !cts_n_s;
        stat_w[ST_RUN_BIT] = run_q;
        stat_w[ST_REMOTE_BIT] = ctrl_q.remote;
        stat_w[ST_RXV_BIT] = rx_valid_q;
        stat_w[ST_LVL_LSB +: LW] = fifo_level;
    end

    always_comb begin
        if (hit_ctrl) rdata_w = 32'(ctrl_q);
        else if (hit_csum) rdata_w = {16'h0000, csum_q};
        else if (hit_stat) rdata_w = stat_w;
        else if (hit_rxd) rdata_w = {23'h000000, rx_valid_q, rx_data_q};
        else rdata_w = 32'h00000000;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
            csum_q <= '0;
            ack_q <= 1'b0;
            dat_q <= '0;
            st_q <= ST_IDLE;
        end else if (ce_i) begin
            ack_q <= ack_d;
            if (rd_acc) dat_q <= rdata_w;
            if (wr_acc && hit_ctrl) ctrl_q <= ctrl_d;
            if (wr_acc && hit_csum) csum_q <= csum_w[15:0];
            st_q <= st_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign go_o = go_q;
    assign abort_o = abort_q;
    assign running_o = run_q;
    assign remote_o = ctrl_q.remote;
    assign rts_n_o = rts_n_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_cr_sent;
        ce_i && tx_start && st_q == ST_TRM1 && ctrl_q.term == TM_CRLF;
    endsequence
    sequence s_lf_next;
        st_q == ST_TRM2 && tx_byte == B_LF;
    endsequence

    baud_legal_a: assert property (ctrl_q.baud <= BR_19200)
        else $error("Illegal rate code held");
    flow_gate_a: assert property ($fell(tx_ready) |-> $past(flow_ok))
        else $error("Byte started against flow control");
    stx_byte_a: assert property (tx_start && st_q == ST_STX |-> tx_byte == B_STX)
        else $error("Start delimiter wrong");
    frame_order_a: assert property (ce_i && tx_start && st_q == ST_PAY && fifo_out.last
            && ctrl_q.frame_en |=> st_q == ST_ETX)
        else $error("End delimiter not after payload");
    csum_order_a: assert property (ce_i && tx_start && st_q == ST_ETX && ctrl_q.csum_en
            |=> st_q == ST_CSH)
        else $error("Checksum not after end delimiter");
    crlf_pair_a: assert property (s_cr_sent |=> s_lf_next)
        else $error("LF not queued after CR");
    term_cr_a: assert property (tx_start && st_q == ST_TRM1 && ctrl_q.term == TM_CR
            |-> tx_byte == B_CR)
        else $error("Default terminator not CR");
    remote_gate_a: assert property (go_o |-> $past(cmd_go) || !$past(ctrl_q.remote))
        else $error("Local go honoured in remote mode");
    stop_abort_a: assert property (ce_i && stop_evt |=> abort_o && !running_o)
        else $error("Stop did not abort");
    ack_drop_a: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
        else $error("Ack held two cycles");
endmodule : shlf_top
`default_nettype wire

// ### shlf_pkg.sv
// Shared constants and types of the serial host-link framer
`default_nettype none
package shlf_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int BAUD_1200 = 1200;
    localparam int BAUD_2400 = 2400;
    localparam int BAUD_4800 = 4800;
    localparam int BAUD_9600 = 9600;
    localparam int BAUD_19200 = 19200;
    localparam int DIV_W = 18;
    localparam int FIFO_DEPTH = 32;

    // Register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_TXDATA = 8'h04;
    localparam logic [7:0] A_CSUM = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0C;
    localparam logic [7:0] A_RXDATA = 8'h10;
    localparam logic [7:0] A_CMD = 8'h14;

    // Bit positions
    localparam int TXD_LAST_BIT = 8;
    localparam int RXD_VALID_BIT = 8;
    localparam int CMD_GO_BIT = 0;
    localparam int CMD_STOP_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_FULL_BIT = 1;
    localparam int ST_XOFF_BIT = 2;
    localparam int ST_CTS_BIT = 3;
    localparam int ST_RUN_BIT = 4;
    localparam int ST_REMOTE_BIT = 5;
    localparam int ST_RXV_BIT = 6;
    localparam int ST_LVL_LSB = 8;

    // Character codes
    localparam logic [7:0] B_STX = 8'h02;
    localparam logic [7:0] B_ETX = 8'h03;
    localparam logic [7:0] B_CR = 8'h0D;
    localparam logic [7:0] B_LF = 8'h0A;
    localparam logic [7:0] B_XON = 8'h11;
    localparam logic [7:0] B_XOFF = 8'h13;

    // Character frame: start, eight data, one stop
    localparam logic [3:0] LAST_BIT_IDX = 4'h9;

    localparam logic [2:0] BR_1200 = 3'h0;
    localparam logic [2:0] BR_2400 = 3'h1;
    localparam logic [2:0] BR_4800 = 3'h2;
    localparam logic [2:0] BR_9600 = 3'h3;
    localparam logic [2:0] BR_19200 = 3'h4;
    localparam logic [1:0] FL_NONE = 2'h0;
    localparam logic [1:0] FL_SW = 2'h1;
    localparam logic [1:0] FL_HW = 2'h2;
    localparam logic [1:0] FL_BOTH = 2'h3;
    localparam logic [1:0] TM_CR = 2'h0;
    localparam logic [1:0] TM_LF = 2'h1;
    localparam logic [1:0] TM_CRLF = 2'h2;

    typedef struct packed {
        logic remote;
        logic [1:0] term;
        logic csum_en;
        logic frame_en;
        logic [1:0] flow;
        logic [2:0] baud;
    } shlf_ctrl_t;
    localparam int CTRL_W = 10;
    localparam shlf_ctrl_t CTRL_RST = '{remote: 1'b0, term: TM_CR, csum_en: 1'b0,
        frame_en: 1'b0, flow: FL_NONE, baud: BR_9600};

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } shlf_entry_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_STX = 3'h1,
        ST_PAY = 3'h2,
        ST_ETX = 3'h3,
        ST_CSH = 3'h4,
        ST_CSL = 3'h5,
        ST_TRM1 = 3'h6,
        ST_TRM2 = 3'h7
    } shlf_state_t;

    function automatic logic [DIV_W-1:0] baud_div(input logic [2:0] sel, input int clk_hz);
        case (sel)
            BR_1200: baud_div = DIV_W'(clk_hz / BAUD_1200);
            BR_2400: baud_div = DIV_W'(clk_hz / BAUD_2400);
            BR_4800: baud_div = DIV_W'(clk_hz / BAUD_4800);
            BR_19200: baud_div = DIV_W'(clk_hz / BAUD_19200);
            default: baud_div = DIV_W'(clk_hz / BAUD_9600);
        endcase
    endfunction : baud_div

    function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        wb_merge = (old_v & ~m) | (new_v & m);
    endfunction : wb_merge
endpackage : shlf_pkg
`default_nettype wire

// ### shlf_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module shlf_fifo #(
    parameter int W = 9,
    parameter int D = 32,
    localparam int AW = $clog2(D)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wr_valid_i,
    input wire logic [W-1:0] wr_data_i,
    output logic wr_ready_o,
    output logic rd_valid_o,
    output logic [W-1:0] rd_data_o,
    input wire logic rd_ready_i,
    output logic [AW:0] level_o
);
    // D must be a power of two: pointers wrap by overflow
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire logic do_wr;
    wire logic do_rd;

    assign wr_ready_o = cnt_q != (AW+1)'(D);
    assign rd_valid_o = cnt_q != '0;
    assign rd_data_o = mem_q[rp_q];
    assign level_o = cnt_q;
    assign do_wr = wr_valid_i && wr_ready_o;
    assign do_rd = rd_valid_o && rd_ready_i;

    always_ff @(posedge clk_i) begin
        if (do_wr && ce_i) begin
            mem_q[wp_q] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (ce_i) begin
            if (do_wr) wp_q <= wp_q + 1'b1;
            if (do_rd) rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    full_blocks_a: assert property (cnt_q == (AW+1)'(D) |-> !wr_ready_o)
        else $error("FIFO accepts data while full");
    level_bound_a: assert property (cnt_q <= (AW+1)'(D))
        else $error("FIFO level above depth");
endmodule : shlf_fifo
`default_nettype wire

// ### shlf_uart_tx.sv
// Asynchronous 8N1 character transmitter
`timescale 1ns/1ps
`default_nettype none
module shlf_uart_tx
    import shlf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [shlf_pkg::DIV_W-1:0] div_i,
    input wire logic start_i,
    input wire logic [7:0] data_i,
    output logic ready_o,
    output logic txd_o
);
    logic [9:0] sh_q;
    logic [3:0] bit_q;
    logic [DIV_W-1:0] cnt_q;
    logic busy_q;

    assign ready_o = !busy_q;
    assign txd_o = sh_q[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            sh_q <= '1;
            bit_q <= '0;
            cnt_q <= '0;
        end else if (ce_i) begin
            if (!busy_q) begin
                if (start_i) begin
                    busy_q <= 1'b1;
                    sh_q <= {1'b1, data_i, 1'b0};
                    bit_q <= '0;
                    cnt_q <= div_i - 1'b1;
                end
            end else if (cnt_q == '0) begin
                cnt_q <= div_i - 1'b1;
                sh_q <= {1'b1, sh_q[9:1]};
                if (bit_q == LAST_BIT_IDX) busy_q <= 1'b0;
                else bit_q <= bit_q + 1'b1;
            end else begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    start_bit_a: assert property (ce_i && start_i && ready_o |=> !txd_o)
        else $error("No start bit after accepted byte");
    stop_bit_a: assert property (busy_q && bit_q == LAST_BIT_IDX |-> txd_o)
        else $error("Stop bit not high");
endmodule : shlf_uart_tx
`default_nettype wire

// ### shlf_host.sv
// Host computer model on the far side of the serial line
`timescale 1ns/1ps
`default_nettype none
module shlf_host
    import shlf_pkg::*;
#(
    parameter int BIT = 10416
) (
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o,
    output logic cts_n_o
);
    logic [7:0] got[$];
    logic [7:0] b;
    initial begin
        rxd_o = 1'b1;
        cts_n_o = 1'b0;
        forever begin
            @(negedge txd_i);
            repeat (BIT / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clk_i);
                b[i] = txd_i;
            end
            repeat (BIT) @(posedge clk_i);
            // A bad stop bit drops the byte, so the count shows it
            if (txd_i === 1'b1) got.push_back(b);
        end
    end
    task automatic hold(input logic v);
        cts_n_o <= v;
    endtask : hold
    task automatic send(input logic [7:0] d);
        for (int i = 0; i < 10; i++) begin
            rxd_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i - 1];
            repeat (BIT) @(posedge clk_i);
        end
    endtask : send
endmodule : shlf_host
`default_nettype wire

// ### testbench.sv
// Self-checking bench of the serial host-link framer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
    import shlf_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic ack, txd, rxd, cts_n, rts_n, go, abort, run, rem, sg, sa;
    logic lgo = 1'b0;
    logic lstop = 1'b0;
    int num_errors = 0;
    int checks_done = 0;
    logic [7:0] exp_s [7] = '{B_STX, 8'h41, B_ETX, 8'h4B, 8'h37, B_CR, B_LF};
    // Nominal clock chosen so one bit at 19200 baud is 32 cycles and the run stays short
    localparam int TB_HZ = 614_400;

    shlf_top #(.CLK_FREQ(TB_HZ)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .rxd_i(rxd), .txd_o(txd), .cts_n_i(cts_n),
        .rts_n_o(rts_n), .local_go_i(lgo), .local_stop_i(lstop), .motion_done_i(1'b0),
        .go_o(go), .abort_o(abort), .running_o(run), .remote_o(rem));
    shlf_host #(.BIT(TB_HZ / BAUD_19200)) host (.clk_i(clk_i), .txd_i(txd),
        .rxd_o(rxd), .cts_n_o(cts_n));

    initial forever #2.5 clk_i = ~clk_i;

    // One classic cycle; one extra edge lets the ack edge's updates land
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK(n, e, rdat)
    endtask : rd
    task automatic loc(input logic s);
        sg = 1'b0;
        sa = 1'b0;
        @(posedge clk_i);
        if (s) lstop <= 1'b1;
        else lgo <= 1'b1;
        repeat (8) begin
            @(posedge clk_i);
            sg |= go;
            sa |= abort;
        end
        lgo <= 1'b0;
        lstop <= 1'b0;
    endtask : loc
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("ctrl", A_CTRL, 32'(CTRL_RST));
        rd("unmapped", 8'h3C, 32'h0);
        $display("test reset done");
        loc(1'b0);
        `CHK("go", 1'b1, sg)
        loc(1'b1);
        `CHK("abort", 1'b1, sa)
        `CHK("stopped", 1'b0, run)
        $display("test local done");
        wb(1'b1, A_CTRL, 32'h203);
        `CHK("remote", 1'b1, rem)
        loc(1'b0);
        `CHK("go ignored", 1'b0, sg)
        wb(1'b1, A_CMD, 32'h1);
        repeat (2) @(posedge clk_i);
        `CHK("cmd go", 1'b1, run)
        loc(1'b1);
        `CHK("stop", 1'b1, sa)
        `CHK("halted", 1'b0, run)
        $display("test remote done");
        // 19200 baud, hardware flow, delimiters, checksum, CR LF
        host.hold(1'b1);
        wb(1'b1, A_CTRL, 32'h174);
        fork
            host.send(8'h52);
        join_none
        wb(1'b1, A_CSUM, 32'h4B37);
        wb(1'b1, A_TXDATA, 32'h141);
        repeat (2000) @(posedge clk_i);
        `CHK("cts hold", 1'b1, txd)
        `CHK("cts none sent", 0, host.got.size())
        host.hold(1'b0);
        while (host.got.size() < 7) @(posedge clk_i);
        for (int i = 0; i < 7; i++) `CHK("byte", exp_s[i], host.got[i])
        `CHK("rts", 1'b1, rts_n)
        rd("rx", A_RXDATA, 32'h152);
        repeat (2) @(posedge clk_i);
        `CHK("rts free", 1'b0, rts_n)
        rd("rx read", A_RXDATA, 32'h052);
        $display("test serial done");
        // XON/XOFF flow, no delimiters, no checksum, LF alone
        wb(1'b1, A_CTRL, 32'h08C);
        host.send(B_XOFF);
        repeat (4) @(posedge clk_i);
        wb(1'b1, A_TXDATA, 32'h141);
        repeat (400) @(posedge clk_i);
        `CHK("xoff hold", 7, host.got.size())
        rd("stat", A_STAT, 32'h10D);
        host.send(B_XON);
        while (host.got.size() < 9) @(posedge clk_i);
        `CHK("bare byte", 8'h41, host.got[7])
        `CHK("lf", B_LF, host.got[8])
        $display("test xon done");
        print_verdict();
    end
    initial begin
        // Tests need about 6000 cycles; the limit gives roughly threefold slack
        #100_000;
        num_errors++;
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
